// ==== rtl/tdol_top.sv ====
// Touch detection, baseline tracking and output combine logic
`timescale 1ns/1ps
`default_nettype none
module tdol_top #(
    parameter int BUTTONS = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire tdol_pkg::tdol_req_t req,
    input wire logic setup_mode,
    input wire logic [1:0] out_enable,
    input wire logic [1:0][15:0] raw_count,
    input wire logic [1:0] raw_valid,
    input wire logic [1:0][7:0] finger_th,
    input wire logic conv_start,
    output logic [7:0] reg_rdata,
    output logic [1:0] output_pin,
    output logic [1:0] sensor_active,
    output logic sense_tick,
    output logic settle_active,
    output logic conv_done
);
    import tdol_pkg::*;

    // ********************************
    // Helpers
    // ********************************
    // Write strobe for one offset
    function automatic logic hit(input tdol_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // Low-bit mask of the sense divider
    function automatic logic [2:0] div_mask(input logic [1:0] s);
        case (s)
            2'b00: return 3'h0;
            2'b01: return 3'h1;
            2'b10: return 3'h3;
            default: return 3'h7;
        endcase
    endfunction

    // Masked OR or AND of sensor states, optionally inverted
    function automatic logic combine(input tdol_cmb_t c, input logic [1:0] m,
                                     input logic [1:0] s);
        return c.inv ^ (c.op ? &(s | ~m) :
                        |(s & m));
    endfunction

    // ********************************
    // Registers
    // ********************************
    tdol_cmb_t cfg_r [2]; // Combine configs
    logic [1:0] sel_r [2]; // Sensor select masks
    logic [1:0] port_r; // Host-written levels
    logic [7:0] noise_r; // Shared noise level
    logic [7:0] bucket_lim_r; // Shared bucket limit
    logic [7:0] settle_r; // Shared settle delay
    logic [1:0] sclk_r; // Sense clock divide
    logic rebase_r; // Auto rebase
    logic [7:0] stick_r; // Shared hysteresis
    logic [7:0] deb_cfg_r; // Shared debounce count

    // Output configs; combine writes ignored while the pin is off, mask writes always taken
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int j = 0; j < 2; j++) begin
                cfg_r[j] <= '0;
                sel_r[j] <= RST_SEL[j];
            end
        end else begin
            for (int j = 0; j < BUTTONS; j++) begin
                // Disabled pin drops the write
                if (hit(req, ADR_CFG[j]) && out_enable[j]) begin
                    cfg_r[j].en <= req.data[CFG_EN_BIT];
                    cfg_r[j].inv <= req.data[CFG_INV_BIT];
                    cfg_r[j].op <= req.data[CFG_OP_BIT];
                end
                // Only sensor states are selectable
                if (hit(req, ADR_SEL[j])) begin
                    sel_r[j] <= req.data[1:0];
                end
            end
        end
    end

    // Direct port, blocked on combine-driven pins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_r <= '0;
        end else if (hit(req, ADR_PORT)) begin
            for (int j = 0; j < BUTTONS; j++) begin
                if (!cfg_r[j].en) begin
                    port_r[j] <= req.data[j];
                end
            end
        end
    end

    // Shared tuning values, one copy for all sensors
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            noise_r <= RST_NOISE;
            bucket_lim_r <= RST_BUCKET;
            settle_r <= RST_SETTLE;
            sclk_r <= '0;
            rebase_r <= 1'b0;
            stick_r <= RST_STICK;
            deb_cfg_r <= RST_DEB;
        end else begin
            if (hit(req, ADR_NOISE)) begin
                noise_r <= req.data;
            end
            // Full byte range accepted
            if (hit(req, ADR_BUCKET)) begin
                bucket_lim_r <= req.data;
            end
            // Timing setup is locked outside setup mode
            if (hit(req, ADR_SETTLE) && setup_mode) begin
                settle_r <= req.data;
            end
            if (hit(req, ADR_SCLK) && setup_mode) begin
                sclk_r <= req.data[SCLK_DIV_LO+1:SCLK_DIV_LO];
                rebase_r <= req.data[SCLK_AR_BIT];
            end
            if (hit(req, ADR_STICK)) begin
                stick_r <= req.data;
            end
            if (hit(req, ADR_DEB)) begin
                deb_cfg_r <= req.data;
            end
        end
    end

    // Read data, valid the cycle after the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (req.rd) begin
            case (req.addr)
                ADR_STATUS: reg_rdata <= {6'h00, output_pin};
                ADR_PORT: reg_rdata <= {6'h00, port_r};
                ADR_CFG[0]: reg_rdata <= {cfg_r[0].en, 5'h00,
                                          cfg_r[0].inv, cfg_r[0].op};
                ADR_SEL[0]: reg_rdata <= {6'h00, sel_r[0]};
                ADR_CFG[1]: reg_rdata <= {cfg_r[1].en, 5'h00,
                                          cfg_r[1].inv, cfg_r[1].op};
                ADR_SEL[1]: reg_rdata <= {6'h00, sel_r[1]};
                ADR_NOISE: reg_rdata <= noise_r;
                ADR_BUCKET: reg_rdata <= bucket_lim_r;
                ADR_SETTLE: reg_rdata <= settle_r;
                ADR_SCLK: reg_rdata <= {1'b0, sclk_r, 1'b0, rebase_r,
                                        3'h0};
                ADR_STICK: reg_rdata <= stick_r;
                ADR_DEB: reg_rdata <= deb_cfg_r;
                default: reg_rdata <= '0; // Unmapped reads zero
            endcase
        end
    end

    // ********************************
    // Sense clock and settle sequencer
    // ********************************
    logic [2:0] div_cnt_r; // Free-running oscillator count
    logic [7:0] settle_cnt_r; // Remaining settle ticks
    tdol_state_t state_r; // Sequencer state

    // Tick at oscillator rate divided by 1, 2, 4 or 8
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt_r <= '0;
            sense_tick <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_r + 3'h1;
            sense_tick <= (div_cnt_r & div_mask(sclk_r)) ==
                          div_mask(sclk_r);
        end
    end

    // Conversion phase lasts settle_r sense ticks, SETTLE_MIN at least
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            settle_cnt_r <= '0;
            settle_active <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (conv_start) begin
                        // Values below the range are raised to it
                        settle_cnt_r <= (settle_r < SETTLE_MIN) ?
                                        SETTLE_MIN : settle_r;
                        settle_active <= 1'b1;
                        state_r <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (sense_tick) begin
                        settle_cnt_r <= settle_cnt_r - 8'h01;
                        if (settle_cnt_r == 8'h01) begin
                            settle_active <= 1'b0;
                            conv_done <= 1'b1;
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ********************************
    // Baseline tracking and detection
    // ********************************
    logic [15:0] base_r [2]; // Baselines
    logic [7:0] bucket_r [2]; // Bucket contents
    logic [7:0] deb_r [2]; // Samples above on-level
    logic [15:0] diff_w [2]; // Positive difference
    logic [16:0] bsum_w [2]; // Bucket plus difference
    logic accum_w [2]; // Sample feeds bucket
    logic [8:0] th_on_w [2]; // Finger plus hysteresis
    logic [8:0] th_off_w [2]; // Finger minus hysteresis
    logic [8:0] deb_min_w; // Debounce target

    // Differences and thresholds
    always_comb begin
        deb_min_w = (deb_cfg_r == 8'h00) ? 9'h001 : {1'b0, deb_cfg_r};
        for (int i = 0; i < 2; i++) begin
            diff_w[i] = (raw_count[i] > base_r[i]) ?
                        raw_count[i] - base_r[i] : 16'h0000;
            bsum_w[i] = {9'h000, bucket_r[i]} + {1'b0, diff_w[i]};
            // Rebase feeds every rise, else only small ones
            accum_w[i] = (raw_count[i] > base_r[i]) &&
                         (rebase_r || (diff_w[i] < {8'h00, noise_r}));
            th_on_w[i] = {1'b0, finger_th[i]} + {1'b0, stick_r};
            th_off_w[i] = (finger_th[i] > stick_r) ?
                          {1'b0, finger_th[i] - stick_r} : 9'h000;
        end
    end

    // Bucket fill and baseline step
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                base_r[i] <= '0;
                bucket_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (raw_valid[i] && accum_w[i]) begin
                    // Full bucket steps baseline and empties
                    if (bsum_w[i] >= {9'h000, bucket_lim_r}) begin
                        base_r[i] <= base_r[i] + 16'h0001;
                        bucket_r[i] <= '0;
                    end else begin
                        bucket_r[i] <= bsum_w[i][7:0];
                    end
                end else if (raw_valid[i] &&
                             raw_count[i] < base_r[i]) begin
                    // Slow downward drift, one count a sample
                    base_r[i] <= base_r[i] - 16'h0001;
                end
            end
        end
    end

    // Finger state with hysteresis and debounce
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sensor_active <= '0;
            for (int i = 0; i < 2; i++) begin
                deb_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (raw_valid[i] && !sensor_active[i]) begin
                    if (diff_w[i] > {7'h00, th_on_w[i]}) begin
                        // Run of samples above must reach target
                        if ({1'b0, deb_r[i]} + 9'h001 >= deb_min_w) begin
                            sensor_active[i] <= 1'b1;
                            deb_r[i] <= '0;
                        end else begin
                            deb_r[i] <= deb_r[i] + 8'h01;
                        end
                    end else begin
                        deb_r[i] <= '0; // Run broken
                    end
                end else if (raw_valid[i] &&
                             diff_w[i] < {7'h00, th_off_w[i]}) begin
                    sensor_active[i] <= 1'b0;
                end
            end
        end
    end

    // ********************************
    // Output combine
    // ********************************
    // Pins register one cycle after the sensor states
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            output_pin <= '0;
        end else begin
            for (int j = 0; j < 2; j++) begin
                if (j >= BUTTONS) begin
                    output_pin[j] <= 1'b0; // Absent on one-button part
                end else if (cfg_r[j].en) begin
                    output_pin[j] <= combine(cfg_r[j], sel_r[j],
                                             sensor_active);
                end else begin
                    output_pin[j] <= port_r[j];
                end
            end
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    cfg_blocked_a: assert property (hit(req, ADR_CFG[0]) &&
        !out_enable[0] |=> $stable(cfg_r[0]))
        else $error("config written while pin disabled");
    port_blocked_a: assert property (hit(req, ADR_PORT) &&
        cfg_r[0].en |=> $stable(port_r[0]))
        else $error("port written on combine pin");
    combine_or_a: assert property (cfg_r[0].en && !cfg_r[0].inv &&
        !cfg_r[0].op && sel_r[0] == 2'b11 |=>
        output_pin[0] == |$past(sensor_active))
        else $error("OR combine wrong");
    combine_inv_a: assert property (cfg_r[0].en && cfg_r[0].inv &&
        !cfg_r[0].op && sel_r[0] == 2'b01 |=>
        output_pin[0] == !$past(sensor_active[0]))
        else $error("inverted combine wrong");
    combine_and_a: assert property (cfg_r[0].en && cfg_r[0].op &&
        !cfg_r[0].inv && sel_r[0] == 2'b11 |=>
        output_pin[0] == &$past(sensor_active))
        else $error("AND combine wrong");
    port_drive_a: assert property (!cfg_r[0].en ##1 !cfg_r[0].en |->
        output_pin[0] == $past(port_r[0]))
        else $error("pin not following port");
    setup_lock_a: assert property (hit(req, ADR_SETTLE) &&
        !setup_mode |=> $stable(settle_r))
        else $error("settle written outside setup");
    noise_hold_a: assert property (raw_valid[0] && !rebase_r &&
        raw_count[0] > base_r[0] && diff_w[0] >= {8'h00, noise_r} |=>
        $stable(base_r[0]) && $stable(bucket_r[0]))
        else $error("baseline moved above noise level");
    div_one_a: assert property (sclk_r == 2'b00 ##1
        sclk_r == 2'b00 |-> sense_tick)
        else $error("undivided tick missing");
    rise_above_a: assert property ($rose(sensor_active[0]) |->
        $past(diff_w[0]) > {7'h00, $past(th_on_w[0])})
        else $error("activated below on-level");
    settle_len_a: assert property (state_r == ST_IDLE && conv_start &&
        sclk_r == 2'b00 && settle_r <= SETTLE_MIN |=> settle_active [*2]
        ##1 conv_done)
        else $error("settle length wrong");

    act_c: cover property ($rose(sensor_active[0]));
    rel_c: cover property ($fell(sensor_active[1]));
    done_c: cover property (conv_done);
    bump_c: cover property (base_r[0] != $past(base_r[0]));
endmodule // tdol_top
`default_nettype wire

// ==== common/tdol_pkg.sv ====
// Shared constants and types for the touch detect and output logic block
package tdol_pkg;
    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_PORT = 8'h04;
    localparam logic [1:0][7:0] ADR_CFG = {8'h21, 8'h1c};
    localparam logic [1:0][7:0] ADR_SEL = {8'h23, 8'h1e};
    localparam logic [7:0] ADR_NOISE = 8'h4e;
    localparam logic [7:0] ADR_BUCKET = 8'h4f;
    localparam logic [7:0] ADR_SETTLE = 8'h50;
    localparam logic [7:0] ADR_SCLK = 8'h51;
    localparam logic [7:0] ADR_STICK = 8'h52;
    localparam logic [7:0] ADR_DEB = 8'h53;
    // ********************************
    // Reset values
    // ********************************
    localparam logic [1:0][1:0] RST_SEL = {2'h2, 2'h1};
    localparam logic [7:0] RST_NOISE = 8'h28;
    localparam logic [7:0] RST_BUCKET = 8'h64;
    localparam logic [7:0] RST_SETTLE = 8'ha0;
    localparam logic [7:0] RST_STICK = 8'h0a;
    localparam logic [7:0] RST_DEB = 8'h0a;
    localparam logic [7:0] SETTLE_MIN = 8'h02;
    // ********************************
    // Field positions
    // ********************************
    localparam int CFG_EN_BIT = 7;
    localparam int CFG_INV_BIT = 1;
    localparam int CFG_OP_BIT = 0;
    localparam int SCLK_DIV_LO = 5;
    localparam int SCLK_AR_BIT = 3;
    // Combine configuration of one output
    typedef struct packed {
        logic en;
        logic inv;
        logic op;
    } tdol_cmb_t;
    // One register access from the serial engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } tdol_req_t;
    // Settle sequencer states, Gray from IDLE through SETTLE to DONE, two bits change back to IDLE
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_DONE = 2'b11
    } tdol_state_t;
endpackage

// ==== bench/tdol_host_model.sv ====
// Host-side register master that drives the request port of the block
`timescale 1ns/1ps
`default_nettype none
module tdol_host_model (
    input wire logic core_clk,
    output var tdol_pkg::tdol_req_t req,
    input wire logic [7:0] rdata
);
    import tdol_pkg::*;
    // ********************************
    // Bus cycles
    // ********************************
    // Idle lines carry inverted values so stale data never matches
    initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, data: 8'hff};
    // One strobe, held across the taking edge, released a cycle later
    task automatic cycle(input logic w, input logic [7:0] a,
                         input logic [7:0] d);
        @(negedge core_clk);
        req <= '{wr: w, rd: !w, addr: a, data: d};
        @(negedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask
    // Register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cycle(1'b1, a, d);
    endtask
    // Register read; data is registered, so it is ready at release
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cycle(1'b0, a, 8'h00);
        d = rdata;
    endtask
    // ********************************
    // Tuning sequence
    // ********************************
    // Settle delay goes first; the levels are clamped to sane values
    task automatic tune(input logic [7:0] settle, input logic [7:0] noise,
                        input logic [7:0] stick, input logic [7:0] ft);
        wr(ADR_SETTLE, settle);
        // Stickiness must stay under the finger level
        if (stick >= ft) stick = ft - 8'h01;
        // Noise floor must sit well under the release level
        if (int'(noise) + int'(stick) + 5 >= int'(ft)) noise = 8'h03;
        if (noise < 8'h03) noise = 8'h03;
        wr(ADR_STICK, stick);
        wr(ADR_NOISE, noise);
    endtask
endmodule // tdol_host_model
`default_nettype wire

// ==== bench/touch_detect_output_logic_bench.sv ====
// Self-checking testbench for the touch detect and output logic block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); \
    end \
end
module touch_detect_output_logic_bench;
    import tdol_pkg::*;
    // ********************************
    // Signals and expectation state
    // ********************************
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    tdol_req_t req;
    logic setup_mode, conv_start;
    logic [1:0] out_enable, raw_valid;
    logic [1:0][15:0] raw_count;
    logic [1:0][7:0] finger_th;
    logic [7:0] reg_rdata, rb, st;
    logic [1:0] output_pin, sensor_active;
    logic sense_tick, settle_active, conv_done;
    int n_mismatch = 0;
    int n_checks = 0;
    int tk, cy, nx, dn;
    logic [31:0] seed = 32'h0000_0012;
    // Model of combine config, masks and port value
    logic [1:0] m_en = 2'h0;
    logic [1:0] m_inv = 2'h0;
    logic [1:0] m_op = 2'h0;
    logic [1:0] m_pm = 2'h0;
    logic [1:0][1:0] m_sel;
    // Reset table: offsets and values, last one unmapped
    localparam logic [7:0] RA [13] = '{8'h1c, 8'h1e, 8'h21, 8'h23, 8'h4e,
        8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h00, 8'h04, 8'h30};
    localparam logic [7:0] RV [13] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h28,
        8'h64, 8'ha0, 8'h00, 8'h0a, 8'h0a, 8'h00, 8'h00, 8'h00};
    // Debounce walk: raw counts and expected finger state
    localparam logic [15:0] DR [13] = '{16'h00c8, 16'h00c8, 16'h0000,
        16'h00c8, 16'h00c8, 16'h00c8, 16'h001e, 16'h000b, 16'h0009,
        16'h001e, 16'h001f, 16'h001f, 16'h001f};
    localparam logic [0:12] DA = 13'h00e1;
    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;
    tdol_top #(.BUTTONS(2)) dut (
        .core_clk(core_clk), .rst(rst), .req(req), .setup_mode(setup_mode),
        .out_enable(out_enable), .raw_count(raw_count),
        .raw_valid(raw_valid), .finger_th(finger_th),
        .conv_start(conv_start), .reg_rdata(reg_rdata),
        .output_pin(output_pin), .sensor_active(sensor_active),
        .sense_tick(sense_tick), .settle_active(settle_active),
        .conv_done(conv_done)
    );
    tdol_host_model host (
        .core_clk(core_clk), .req(req), .rdata(reg_rdata)
    );
    // ********************************
    // Helpers
    // ********************************
    // Repeatable pseudo-random step
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // Expected pin: combine of masked sensors, else the port bit
    function automatic logic pin_exp(input int j, input logic [1:0] s);
        logic r;
        r = m_op[j] ? &(s | ~m_sel[j]) : |(s & m_sel[j]);
        return m_en[j] ? r ^ m_inv[j] : m_pm[j];
    endfunction
    // One new sample on both sensors at once
    task automatic sample(input logic [15:0] r0, input logic [15:0] r1);
        @(negedge core_clk);
        raw_count = {r1, r0};
        raw_valid = 2'b11;
        @(negedge core_clk);
        raw_valid = 2'b00;
    endtask
    // Single place where the run ends
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog at 20000 cycles, far beyond the fewer than 1500 cycles the run needs
    initial begin
        #500000;
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done();
    end
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        setup_mode = 1'b0;
        conv_start = 1'b0;
        out_enable = 2'b11;
        raw_valid = 2'b00;
        raw_count = '0;
        finger_th = {8'h14, 8'h14};
        m_sel = {2'h2, 2'h1};
        repeat (4) @(negedge core_clk);
        `CHK(output_pin, 2'b00)
        rst = 1'b0;
        // Reset values, then bucket limit at both ends of its range
        for (int i = 0; i < 13; i++) begin
            host.rd(RA[i], rb);
            `CHK(rb, RV[i])
        end
        for (int v = 0; v < 2; v++) begin
            host.wr(ADR_BUCKET, {8{v[0]}});
            host.rd(ADR_BUCKET, rb);
            `CHK(rb, {8{v[0]}})
        end
        $display("test reset_values done");
        // Every clock divide: setup gating, tick rate, settle length
        for (int dv = 0; dv < 4; dv++) begin
            seed = xs(seed);
            st = (dv == 0) ? 8'h00 : {4'h0, seed[3:0]};
            setup_mode = 1'b1;
            host.wr(ADR_SCLK, {1'b0, dv[1:0], 5'h00});
            host.tune(st, 8'h03, 8'h0a, 8'h14);
            setup_mode = 1'b0;
            host.wr(ADR_SETTLE, 8'h07);
            host.wr(ADR_SCLK, 8'h68);
            host.rd(ADR_SETTLE, rb);
            `CHK(rb, st)
            host.rd(ADR_SCLK, rb);
            `CHK(rb, {1'b0, dv[1:0], 5'h00})
            tk = 0;
            repeat (64) begin
                @(negedge core_clk);
                if (sense_tick === 1'b1) tk++;
            end
            `CHK(tk, 64 >> dv)
            // Values under the minimum act as the minimum
            nx = (st < SETTLE_MIN) ? 2 : int'(st);
            conv_start = 1'b1;
            @(negedge core_clk);
            conv_start = 1'b0;
            tk = 0;
            cy = 0;
            dn = 0;
            for (int k = 0; k < 400 && dn == 0; k++) begin
                if (settle_active === 1'b1) cy++;
                if (settle_active === 1'b1 && sense_tick === 1'b1) tk++;
                if (conv_done === 1'b1) dn = 1;
                else @(negedge core_clk);
            end
            `CHK(dn, 1)
            `CHK(tk, nx)
            if (dv == 0) `CHK(cy, nx)
        end
        $display("test settle_clock done");
        // Debounce of three and hysteresis on both sensors together
        host.wr(ADR_DEB, 8'h03);
        for (int k = 0; k < 13; k++) begin
            sample(DR[k], DR[k]);
            `CHK(sensor_active, {2{DA[k]}})
        end
        $display("test debounce done");
        // Random combine settings, pin enables, sensors and port
        host.wr(ADR_DEB, 8'h01);
        for (int it = 0; it < 48; it++) begin
            seed = xs(seed);
            out_enable = seed[1:0];
            sample(seed[2] ? 16'h00c8 : 16'h0000,
                   seed[3] ? 16'h00c8 : 16'h0000);
            for (int j = 0; j < 2; j++) begin
                host.wr(ADR_CFG[j],
                        {seed[8+j], 5'h00, seed[10+j], seed[12+j]});
                // Config only sticks while the pin is enabled
                if (out_enable[j]) begin
                    m_en[j] = seed[8+j];
                    m_inv[j] = seed[10+j];
                    m_op[j] = seed[12+j];
                end
                host.wr(ADR_SEL[j], {6'h00, seed[15+2*j -: 2]});
                m_sel[j] = seed[15+2*j -: 2];
            end
            host.wr(ADR_PORT, {6'h00, seed[19:18]});
            // Port bits stick only on pins not owned by the combine
            for (int j = 0; j < 2; j++) begin
                if (!m_en[j]) m_pm[j] = seed[18+j];
            end
            `CHK(sensor_active, seed[3:2])
            @(negedge core_clk);
            `CHK(output_pin[0], pin_exp(0, seed[3:2]))
            `CHK(output_pin[1], pin_exp(1, seed[3:2]))
            host.rd(ADR_CFG[it[0]], rb);
            `CHK(rb, {m_en[it[0]], 5'h00, m_inv[it[0]], m_op[it[0]]})
        end
        $display("test combine done");
        // Bucket of four: two small rises lift the baseline by one
        host.wr(ADR_BUCKET, 8'h04);
        sample(16'h0002, 16'h0002);
        sample(16'h0002, 16'h0002);
        // Diff 30 sits on the on-level, so no activation
        sample(16'h001f, 16'h001f);
        `CHK(sensor_active, 2'b00)
        // The large rise must not have moved the baseline
        sample(16'h0020, 16'h0020);
        `CHK(sensor_active, 2'b11)
        // Auto rebase: every rise now feeds the bucket
        setup_mode = 1'b1;
        host.wr(ADR_SCLK, 8'h08);
        setup_mode = 1'b0;
        repeat (30) sample(16'h0028, 16'h0028);
        `CHK(sensor_active, 2'b11)
        sample(16'h0028, 16'h0028);
        `CHK(sensor_active, 2'b00)
        $display("test baseline done");
        test_done();
    end
endmodule // touch_detect_output_logic_bench
`default_nettype wire
